// ### logic/irqep_top.v
// interrupt enable and priority registers with masking and level arbitration
`include "irqep_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - bit 7 of core enable gates every source; 0 blocks all
// R2 - timer 2 overflow requests pass only while core enable bit 5 set
// R3 - uart rx or tx flag requests when core enable bit 4 set
// R4 - timer 1 overflow (timer control bit 7) needs core enable bit 3
// R5 - timer 0 overflow (timer control bit 5) needs core enable bit 1
// R6 - external pin 0 needs enable bit 0, pin 1 needs bit 2
// R7 - unused enable/priority bits read zero, writes to them ignored
// R8 - software writes 0 to extended enable bit 6; it reads 0
// R9 - core priority bits 5..0 give levels of six core sources
// R10 - crystal-valid flag requests need extended enable bit 7
// R11 - extended enable bits 5..2 mask software interrupts 3..0
// R12 - converter end-of-conversion requests need extended enable bit 1
// R13 - extended priority bits 7..4 set comparator edge levels
// R14 - extended priority bit 2 sets converter window compare level
// R15 - extended priority bit 0 sets serial peripheral level
// R16 - reset clears all four registers to zero
// R17 - high level preempts low service; equal or lower waits
module irqep_top (
  input wire REF_CLK,
  input wire RESET,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  input wire SFR_WR,
  input wire SFR_RD,
  output reg [7:0] SFR_RDATA,
  input wire TMR2_OVERFLOW_FLAG,
  input wire UART_RX_FLAG,
  input wire UART_TX_FLAG,
  input wire TMR1_OVERFLOW_FLAG,
  input wire TMR0_OVERFLOW_FLAG,
  input wire EXT_IRQ_PIN0,
  input wire EXT_IRQ_PIN1,
  input wire XTAL_OK_FLAG,
  input wire [3:0] SOFT_IRQ_BITS,
  input wire CONV_DONE_FLAG,
  input wire CMP1_RISE_REQ,
  input wire CMP1_FALL_REQ,
  input wire CMP0_RISE_REQ,
  input wire CMP0_FALL_REQ,
  input wire CONV_WINDOW_REQ,
  input wire SERIAL_PERIPH_REQ,
  input wire IRQ_ACK,
  input wire IRQ_RETURN,
  output reg IRQ_REQ,
  output reg [4:0] IRQ_VECTOR,
  output reg IRQ_HIGH,
  output reg [7:0] CORE_IRQ_ENABLE,
  output reg [7:0] CORE_IRQ_PRIORITY,
  output reg [7:0] EXTENDED_IRQ_ENABLE_B,
  output reg [7:0] EXTENDED_IRQ_PRIORITY_A
);
  reg [7:0] core_en_q;
  reg [7:0] core_pri_q;
  reg [7:0] ext_en_q;
  reg [7:0] ext_pri_q;
  reg in_low_q;
  reg in_high_q;
  wire [1:0] pin_sync;
  wire [`IRQEP_NSRC-1:0] raw;
  reg [`IRQEP_NSRC-1:0] mask;
  reg [`IRQEP_NSRC-1:0] level;
  wire [`IRQEP_NSRC-1:0] pend;
  wire [`IRQEP_NSRC-1:0] pend_hi;
  wire [`IRQEP_NSRC-1:0] pend_lo;
  reg [4:0] vec_d;
  reg hi_d;
  reg req_d;
  // pins are active low and asynchronous, so they are synchronised first
  irqep_sync #(.WIDTH(2)) u_pin_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .din({~EXT_IRQ_PIN1, ~EXT_IRQ_PIN0}),
    .dout(pin_sync)
  );
  // source order is the fixed natural priority, lowest index first
  assign raw = {SERIAL_PERIPH_REQ, CONV_WINDOW_REQ, CMP0_FALL_REQ,
    CMP0_RISE_REQ, CMP1_FALL_REQ, CMP1_RISE_REQ, CONV_DONE_FLAG,
    SOFT_IRQ_BITS, XTAL_OK_FLAG, TMR2_OVERFLOW_FLAG,
    UART_RX_FLAG | UART_TX_FLAG, pin_sync[1], TMR1_OVERFLOW_FLAG,
    TMR0_OVERFLOW_FLAG, pin_sync[0]}; // R3
  function addr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      addr_hit = (a == target);
    end
  endfunction
  always @*
  begin
    mask = {`IRQEP_NSRC{1'b0}};
    mask[0] = core_en_q[`IRQEP_BIT_EXT0]; // R6
    mask[1] = core_en_q[`IRQEP_BIT_TMR0]; // R5
    mask[2] = core_en_q[`IRQEP_BIT_TMR1]; // R4
    mask[3] = core_en_q[`IRQEP_BIT_EXT1]; // R6
    mask[4] = core_en_q[`IRQEP_BIT_UART]; // R3
    mask[5] = core_en_q[`IRQEP_BIT_TMR2]; // R2
    mask[6] = ext_en_q[`IRQEP_BIT_XTAL]; // R10
    mask[10:7] = ext_en_q[5:2]; // R11
    mask[11] = ext_en_q[`IRQEP_BIT_CONV]; // R12
    // comparator, window and serial sources have masks held elsewhere
    mask[17:12] = 6'h3f;
    level = {`IRQEP_NSRC{1'b0}};
    level[0] = core_pri_q[`IRQEP_BIT_EXT0]; // R9
    level[1] = core_pri_q[`IRQEP_BIT_TMR0]; // R9
    level[2] = core_pri_q[`IRQEP_BIT_TMR1]; // R9
    level[3] = core_pri_q[`IRQEP_BIT_EXT1]; // R9
    level[4] = core_pri_q[`IRQEP_BIT_UART]; // R9
    level[5] = core_pri_q[`IRQEP_BIT_TMR2]; // R9
    level[12] = ext_pri_q[7]; // R13
    level[13] = ext_pri_q[6]; // R13
    level[14] = ext_pri_q[5]; // R13
    level[15] = ext_pri_q[4]; // R13
    level[16] = ext_pri_q[2]; // R14
    level[17] = ext_pri_q[0]; // R15
  end
  assign pend = raw & mask & {`IRQEP_NSRC{core_en_q[`IRQEP_BIT_GLOBAL]}}; // R1
  assign pend_hi = pend & level;
  assign pend_lo = pend & ~level;
  integer i;
  always @*
  begin
    vec_d = 5'h00;
    hi_d = 1'b0;
    req_d = 1'b0;
    // nothing outranks a running high service; low waits for any service
    if (!in_high_q && (|pend_hi))
    begin
      req_d = 1'b1;
      hi_d = 1'b1;
      for (i = `IRQEP_NSRC - 1; i >= 0; i = i - 1)
        if (pend_hi[i])
          vec_d = i[4:0];
    end
    else if (!in_high_q && !in_low_q && (|pend_lo))
    begin
      req_d = 1'b1;
      for (i = `IRQEP_NSRC - 1; i >= 0; i = i - 1)
        if (pend_lo[i])
          vec_d = i[4:0];
    end // R17
  end
  always @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      core_en_q <= `IRQEP_RESET_VALUE; // R16
      core_pri_q <= `IRQEP_RESET_VALUE; // R16
      ext_en_q <= `IRQEP_RESET_VALUE; // R16
      ext_pri_q <= `IRQEP_RESET_VALUE; // R16
    end
    else if (SFR_WR)
    begin
      if (addr_hit(SFR_ADDR, `IRQEP_ADDR_CORE_EN))
        core_en_q <= SFR_WDATA & `IRQEP_CORE_EN_MASK; // R7
      else if (addr_hit(SFR_ADDR, `IRQEP_ADDR_CORE_PRI))
        core_pri_q <= SFR_WDATA & `IRQEP_CORE_PRI_MASK; // R7
      else if (addr_hit(SFR_ADDR, `IRQEP_ADDR_EXT_EN))
        ext_en_q <= SFR_WDATA & `IRQEP_EXT_EN_MASK; // R8
      else if (addr_hit(SFR_ADDR, `IRQEP_ADDR_EXT_PRI))
        ext_pri_q <= SFR_WDATA & `IRQEP_EXT_PRI_MASK; // R7
    end
  end
  // service levels: acknowledge enters the offered level, return leaves
  // the innermost one
  always @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      in_low_q <= 1'b0;
      in_high_q <= 1'b0;
    end
    else if (IRQ_ACK && IRQ_REQ)
    begin
      if (IRQ_HIGH)
        in_high_q <= 1'b1; // R17
      else
        in_low_q <= 1'b1;
    end
    else if (IRQ_RETURN)
    begin
      if (in_high_q)
        in_high_q <= 1'b0;
      else
        in_low_q <= 1'b0;
    end
  end
  always @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      SFR_RDATA <= 8'h00;
      IRQ_REQ <= 1'b0;
      IRQ_VECTOR <= 5'h00;
      IRQ_HIGH <= 1'b0;
      CORE_IRQ_ENABLE <= 8'h00;
      CORE_IRQ_PRIORITY <= 8'h00;
      EXTENDED_IRQ_ENABLE_B <= 8'h00;
      EXTENDED_IRQ_PRIORITY_A <= 8'h00;
    end
    else
    begin
      // request is withdrawn the cycle it is acknowledged
      IRQ_REQ <= req_d & ~(IRQ_ACK & IRQ_REQ);
      IRQ_VECTOR <= vec_d;
      IRQ_HIGH <= hi_d;
      CORE_IRQ_ENABLE <= core_en_q;
      CORE_IRQ_PRIORITY <= core_pri_q;
      EXTENDED_IRQ_ENABLE_B <= ext_en_q;
      EXTENDED_IRQ_PRIORITY_A <= ext_pri_q;
      if (!SFR_RD)
        SFR_RDATA <= 8'h00;
      else if (addr_hit(SFR_ADDR, `IRQEP_ADDR_CORE_EN))
        SFR_RDATA <= core_en_q;
      else if (addr_hit(SFR_ADDR, `IRQEP_ADDR_CORE_PRI))
        SFR_RDATA <= core_pri_q;
      else if (addr_hit(SFR_ADDR, `IRQEP_ADDR_EXT_EN))
        SFR_RDATA <= ext_en_q;
      else if (addr_hit(SFR_ADDR, `IRQEP_ADDR_EXT_PRI))
        SFR_RDATA <= ext_pri_q;
      else
        SFR_RDATA <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### logic/irqep_defines.vh
// offsets, field positions and reset values of the interrupt enable/priority registers
`ifndef IRQEP_DEFINES_VH
`define IRQEP_DEFINES_VH
`define IRQEP_ADDR_CORE_EN 8'ha8
`define IRQEP_ADDR_CORE_PRI 8'hb8
`define IRQEP_ADDR_EXT_EN 8'he7
`define IRQEP_ADDR_EXT_PRI 8'hf6
`define IRQEP_CORE_EN_MASK 8'hbf
`define IRQEP_CORE_PRI_MASK 8'h3f
`define IRQEP_EXT_EN_MASK 8'hbe
`define IRQEP_EXT_PRI_MASK 8'hf5
`define IRQEP_RESET_VALUE 8'h00
`define IRQEP_BIT_GLOBAL 7
`define IRQEP_BIT_TMR2 5
`define IRQEP_BIT_UART 4
`define IRQEP_BIT_TMR1 3
`define IRQEP_BIT_EXT1 2
`define IRQEP_BIT_TMR0 1
`define IRQEP_BIT_EXT0 0
`define IRQEP_BIT_XTAL 7
`define IRQEP_BIT_CONV 1
`define IRQEP_NSRC 18
`endif

// ### logic/irqep_sync.v
// two-flop synchroniser bank for asynchronous request pins
`timescale 1ns/1ps
`default_nettype none
module irqep_sync #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_q;
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### tb/irqep_core.sv
// core-side partner that accepts offered requests and ends services
`timescale 1ns/1ps
`default_nettype none
module irqep_core (
  input wire logic clk,
  input wire logic req,
  input wire logic take,
  input wire logic back,
  output logic ack = 1'h0,
  output logic ret = 1'h0
);
  // acks only a request still on offer, one cycle at a time
  always @(posedge clk)
  begin
    ack <= take && req && !ack;
    ret <= back && !ret;
  end
endmodule
`default_nettype wire

// ### tb/irqep_top_asserts.sv
// port-level checks of register mirrors and request arbitration
`timescale 1ns/1ps
`default_nettype none
module irqep_top_asserts (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic IRQ_REQ,
  input wire logic [4:0] IRQ_VECTOR,
  input wire logic IRQ_HIGH,
  input wire logic IRQ_ACK,
  input wire logic IRQ_RETURN,
  input wire logic [7:0] CORE_IRQ_ENABLE,
  input wire logic [7:0] CORE_IRQ_PRIORITY,
  input wire logic [7:0] EXTENDED_IRQ_ENABLE_B,
  input wire logic [7:0] EXTENDED_IRQ_PRIORITY_A,
  input wire logic TMR2_OVERFLOW_FLAG,
  input wire logic TMR0_OVERFLOW_FLAG
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence hi_svc;
    IRQ_ACK && IRQ_HIGH ##1 !IRQ_RETURN [*2];
  endsequence
  sequence lo_svc;
    IRQ_ACK && !IRQ_HIGH ##1 !IRQ_RETURN [*2];
  endsequence
  reset_clear_a: assert property ($fell(RESET) |-> !IRQ_REQ &&
    (CORE_IRQ_ENABLE | CORE_IRQ_PRIORITY | EXTENDED_IRQ_ENABLE_B |
    EXTENDED_IRQ_PRIORITY_A) == 8'h00) else $error("reset values");
  unused_zero_a: assert property (!CORE_IRQ_ENABLE[6] &&
    CORE_IRQ_PRIORITY[7:6] == 2'h0 && !EXTENDED_IRQ_ENABLE_B[0] &&
    !EXTENDED_IRQ_PRIORITY_A[3] && !EXTENDED_IRQ_PRIORITY_A[1])
    else $error("unused bit set");
  resv_bit_a: assert property (!EXTENDED_IRQ_ENABLE_B[6])
    else $error("reserved bit set");
  gate_off_a: assert property (!CORE_IRQ_ENABLE[7] [*2] |-> !IRQ_REQ)
    else $error("request with gate off");
  tmr2_gate_a: assert property (IRQ_REQ && IRQ_VECTOR == 5'h05 |->
    $past(TMR2_OVERFLOW_FLAG) && CORE_IRQ_ENABLE[5] && CORE_IRQ_ENABLE[7])
    else $error("timer 2 request not enabled");
  tmr0_level_a: assert property (IRQ_REQ && IRQ_VECTOR == 5'h01 |->
    $past(TMR0_OVERFLOW_FLAG) && CORE_IRQ_ENABLE[1] &&
    IRQ_HIGH == CORE_IRQ_PRIORITY[1]) else $error("timer 0 request");
  hi_block_a: assert property (hi_svc |-> !IRQ_REQ)
    else $error("offer during high service");
  lo_wait_a: assert property (lo_svc |-> !IRQ_REQ || IRQ_HIGH)
    else $error("low offer during low service");
endmodule
bind irqep_top irqep_top_asserts chk (.*);
`default_nettype wire

// ### tb/irqep_bench.sv
// self-checking bench of the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module irqep_bench;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, take = 1'h0;
  logic back = 1'h0, req, hi, ack, ret, rq, eh, la = 1'h0, ha = 1'h0;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdat, m0, m1, m2, m3;
  logic [18:0] s = 19'h60;
  logic [4:0] vec, ev;
  logic [17:0] pd, lv;
  logic [7:0] r [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] at [4] = '{8'ha8, 8'hb8, 8'he7, 8'hf6};
  logic [7:0] mk [4] = '{8'hbf, 8'h3f, 8'hbe, 8'hf5};
  int error_cnt = 0, tests_run = 0, seed = 32'h826b8dc3, k, n;
  always #5 clk = ~clk;
  irqep_top DUT (.REF_CLK(clk), .RESET(rst), .SFR_ADDR(ad), .SFR_WDATA(wd),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdat), .TMR2_OVERFLOW_FLAG(s[0]),
    .UART_RX_FLAG(s[1]), .UART_TX_FLAG(s[2]), .TMR1_OVERFLOW_FLAG(s[3]),
    .TMR0_OVERFLOW_FLAG(s[4]), .EXT_IRQ_PIN0(s[5]), .EXT_IRQ_PIN1(s[6]),
    .XTAL_OK_FLAG(s[7]), .SOFT_IRQ_BITS(s[11:8]), .CONV_DONE_FLAG(s[12]),
    .CMP1_RISE_REQ(s[13]), .CMP1_FALL_REQ(s[14]), .CMP0_RISE_REQ(s[15]),
    .CMP0_FALL_REQ(s[16]), .CONV_WINDOW_REQ(s[17]),
    .SERIAL_PERIPH_REQ(s[18]), .IRQ_ACK(ack), .IRQ_RETURN(ret),
    .IRQ_REQ(req), .IRQ_VECTOR(vec), .IRQ_HIGH(hi), .CORE_IRQ_ENABLE(m0),
    .CORE_IRQ_PRIORITY(m1), .EXTENDED_IRQ_ENABLE_B(m2),
    .EXTENDED_IRQ_PRIORITY_A(m3));
  irqep_core core (.clk(clk), .req(req), .take(take), .back(back),
    .ack(ack), .ret(ret));
  task summarize;
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wreg(input logic [7:0] a, d);
    @(negedge clk);
    ad = a;
    wd = (a == 8'he7) ? d & 8'hbf : d;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
    for (int i = 0; i < 4; i++)
      if (a == at[i])
        r[i] = wd & mk[i];
  endtask
  task rreg(input logic [7:0] a, e);
    @(negedge clk);
    ad = a;
    rd = 1'h1;
    @(negedge clk);
    rd = 1'h0;
    `CHK("rdata", e, rdat)
  endtask
  // pins go through a two-flop sync, so four cycles covers every source
  task arb;
    repeat (4) @(negedge clk);
    pd = {s[18:12], s[11:8], s[7], s[0], s[1] | s[2], ~s[6], s[3], s[4], ~s[5]}
      & {6'h3f, r[2][1], r[2][5:2], r[2][7], r[0][5], r[0][4], r[0][2],
      r[0][3], r[0][1], r[0][0]} & {18{r[0][7]}};
    lv = {r[3][0], r[3][2], r[3][4], r[3][5], r[3][6], r[3][7], 6'h00,
      r[1][5], r[1][4], r[1][2], r[1][3], r[1][1], r[1][0]};
    eh = 1'h0;
    ev = 5'h00;
    for (int i = 17; i >= 0; i--)
      if (pd[i] && (lv[i] || !eh))
      begin
        ev = 5'(i);
        eh = lv[i];
      end
    rq = |pd && !ha && (eh || !la);
    `CHK("req", rq, req)
    if (rq)
    begin
      `CHK("vector", ev, vec)
      `CHK("level", eh, hi)
    end
  endtask
  // a take accepts at the offered level, a back ends the innermost service
  task pulse(input logic t);
    @(negedge clk);
    take = t;
    back = !t;
    if (t)
      {ha, la} = eh ? {1'h1, la} : 2'h1;
    else
      {ha, la} = ha ? {1'h0, la} : 2'h0;
    repeat (2) @(negedge clk);
    take = 1'h0;
    back = 1'h0;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'h0;
    for (k = 0; k < 4; k++)
      rreg(at[k], 8'h00);
    for (k = 0; k < 4; k++)
    begin
      wreg(at[k], 8'hff);
      rreg(at[k], r[k]);
    end
    wreg(8'ha9, 8'hff);
    rreg(8'ha9, 8'h00);
    for (n = 0; n < 300; n++)
    begin
      k = $unsigned($random(seed)) % 4;
      wreg(at[k], $random(seed));
      s = $random(seed);
      arb;
    end
    wreg(8'ha8, 8'hbf);
    wreg(8'hb8, 8'h20);
    wreg(8'he7, 8'h00);
    wreg(8'hf6, 8'h00);
    s = 19'h70;
    arb;
    pulse(1'h1);
    arb;
    s = 19'h71;
    arb;
    pulse(1'h1);
    arb;
    s = 19'h70;
    pulse(1'h0);
    arb;
    pulse(1'h0);
    arb;
    summarize;
  end
  initial
  begin
    #100000;
    error_cnt++;
    summarize;
  end
endmodule
`default_nettype wire
